// [hw/atc_cfg.svh]
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH

// ==========================================================================
// Task-file offsets
// ==========================================================================
`define ATC_OFF_FEAT_ERR  4'h1
`define ATC_OFF_SCOUNT    4'h2
`define ATC_OFF_SNUM      4'h3
`define ATC_OFF_CYL_LO    4'h4
`define ATC_OFF_CYL_HI    4'h5
`define ATC_OFF_DH        4'h6
`define ATC_OFF_STAT_CMD  4'h7
`define ATC_OFF_ALT_CTRL  4'he
`define ATC_OFF_DRV_ECHO  4'hf

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define ATC_DH_LBA_BIT    6
`define ATC_DH_DRV_BIT    4
`define ATC_DH_RST        8'ha0
`define ATC_CTRL_SRST_BIT 2
`define ATC_ERR_ABRT_BIT  2
`define ATC_ST_BSY        7
`define ATC_ST_RDY        6
`define ATC_ST_DWF        5
`define ATC_ST_DSC        4
`define ATC_ST_DRQ        3
`define ATC_ST_ERR        0
`define ATC_ECHO_WR_GATE  6
`define ATC_ECHO_DS1      1
`define ATC_ECHO_DS0      0
`define ATC_BSY_ONLY      8'h80
`define ATC_USE_FR        0
`define ATC_USE_SC        1
`define ATC_USE_SN        2
`define ATC_USE_CY        3
`define ATC_USE_DH        4
`define ATC_USE_LBA       5

// ==========================================================================
// Timing
// ==========================================================================
`define ATC_CLK_PERIOD_PS 25000
`define ATC_BSY_SET_NS    400
`define ATC_BSY_SET_CYC   ((`ATC_BSY_SET_NS * 1000) / `ATC_CLK_PERIOD_PS)
`define ATC_DRQ2_US       700
`define ATC_DRQ2_CYC      ((`ATC_DRQ2_US * 64'd1000000) / `ATC_CLK_PERIOD_PS)
`define ATC_DRQ3_MS       20
`define ATC_DRQ3_CYC      ((`ATC_DRQ3_MS * 64'd1000000000) / `ATC_CLK_PERIOD_PS)

// ==========================================================================
// Command codes
// ==========================================================================
`define ATC_C_CHKPWR_A    8'he5
`define ATC_C_CHKPWR_B    8'h98
`define ATC_C_DIAG        8'h90
`define ATC_C_ERASE       8'hc0
`define ATC_C_FORMAT      8'h50
`define ATC_C_IDENT       8'hec
`define ATC_C_IDLE_A      8'he3
`define ATC_C_IDLE_B      8'h97
`define ATC_C_IDLEI_A     8'he1
`define ATC_C_IDLEI_B     8'h95
`define ATC_C_INITP       8'h91
`define ATC_C_RDBUF       8'he4
`define ATC_C_RDDMA       8'hc8
`define ATC_C_RDMUL       8'hc4
`define ATC_C_RD_A        8'h20
`define ATC_C_RD_B        8'h21
`define ATC_C_VFY_A       8'h40
`define ATC_C_VFY_B       8'h41
`define ATC_C_RECAL       8'h1?
`define ATC_C_SENSE       8'h03
`define ATC_C_SEEK        8'h7?
`define ATC_C_SETFEAT     8'hef
`define ATC_C_SETMUL      8'hc6
`define ATC_C_SLEEP_A     8'he6
`define ATC_C_SLEEP_B     8'h99
`define ATC_C_STBY_A      8'he2
`define ATC_C_STBY_B      8'h96
`define ATC_C_STBYI_A     8'he0
`define ATC_C_STBYI_B     8'h94
`define ATC_C_XLATE       8'h87
`define ATC_C_WEAR        8'hf5
`define ATC_C_WRBUF       8'he8
`define ATC_C_WRDMA       8'hca
`define ATC_C_WRMUL       8'hc5
`define ATC_C_WRMUL_NE    8'hcd
`define ATC_C_WR_A        8'h30
`define ATC_C_WR_B        8'h31
`define ATC_C_WR_NE       8'h38
`define ATC_C_WRVFY       8'h3c

`endif

// [hw/atc_pkg.sv]
package atc_pkg;

   // Acceptance class of a decoded command; none marks an unsupported code.
   typedef enum logic [1:0] {
      ATC_CLS_NONE,
      ATC_CLS_1,
      ATC_CLS_2,
      ATC_CLS_3
   } atc_class_t;

   // Command sequencer states.
   typedef enum logic [2:0] {
      ATC_IDLE,
      ATC_EXEC,
      ATC_PREP,
      ATC_HANDOFF,
      ATC_XFER,
      ATC_FAIL
   } atc_state_t;

endpackage

// [hw/atc_decode.sv]
`include "atc_cfg.svh"

module atc_decode
   import atc_pkg::*;
(
   input  wire logic [7:0] code,
   output atc_class_t      cls,
   output logic [5:0]      use_mask,
   output logic            is_write
);

   localparam logic [5:0] U_MEDIA = 6'h3e;
   localparam logic [5:0] U_FMT   = 6'h3a;
   localparam logic [5:0] U_SEEK  = 6'h3c;
   localparam logic [5:0] U_SCDH  = 6'h12;
   localparam logic [5:0] U_FRDH  = 6'h11;
   localparam logic [5:0] U_DH    = 6'h10;

   // Command table: class, used registers with LBA support, and write nature.
   always_comb begin
      cls      = ATC_CLS_1;
      use_mask = U_DH;
      is_write = 1'b0;
      casez (code)
         `ATC_C_ERASE, `ATC_C_RDDMA, `ATC_C_RDMUL, `ATC_C_RD_A, `ATC_C_RD_B,
         `ATC_C_VFY_A, `ATC_C_VFY_B, `ATC_C_XLATE: begin
            use_mask = U_MEDIA;
         end
         `ATC_C_WRDMA: begin
            use_mask = U_MEDIA;
            is_write = 1'b1;
         end
         `ATC_C_WRMUL, `ATC_C_WRMUL_NE, `ATC_C_WR_A, `ATC_C_WR_B, `ATC_C_WR_NE: begin
            cls      = ATC_CLS_2;
            use_mask = U_MEDIA;
            is_write = 1'b1;
         end
         `ATC_C_WRVFY: begin
            cls      = ATC_CLS_3;
            use_mask = U_MEDIA;
            is_write = 1'b1;
         end
         `ATC_C_FORMAT: begin
            cls      = ATC_CLS_2;
            use_mask = U_FMT;
            is_write = 1'b1;
         end
         `ATC_C_SEEK: use_mask = U_SEEK;
         `ATC_C_IDLE_A, `ATC_C_IDLE_B, `ATC_C_INITP, `ATC_C_SETMUL: begin
            use_mask = U_SCDH;
         end
         `ATC_C_SETFEAT: use_mask = U_FRDH;
         `ATC_C_WRBUF: begin
            cls      = ATC_CLS_2;
            is_write = 1'b1;
         end
         `ATC_C_CHKPWR_A, `ATC_C_CHKPWR_B, `ATC_C_DIAG, `ATC_C_IDENT,
         `ATC_C_IDLEI_A, `ATC_C_IDLEI_B, `ATC_C_RDBUF, `ATC_C_RECAL,
         `ATC_C_SENSE, `ATC_C_SLEEP_A, `ATC_C_SLEEP_B, `ATC_C_STBY_A,
         `ATC_C_STBY_B, `ATC_C_STBYI_A, `ATC_C_STBYI_B, `ATC_C_WEAR: begin
            use_mask = U_DH;
         end
         default: begin
            cls      = ATC_CLS_NONE;
            use_mask = 6'h00;
         end
      endcase
   end

endmodule

// [hw/atc_core.sv]
// Functional notes
// - Drive-address bit 6 reads low during a write, high otherwise.
// - Drive-address bits 5..2 return inverted head bits 3..0 in order.
// - Drive-address bit 1 reads zero when drive 1 is active and selected.
// - Drive-address bit 0 reads zero when drive 0 is active and selected.
// - Class 1 command raises busy within 400 ns of the code write.
// - Class 2: busy, prepare buffer, data request within 700 us, busy clears.
// - Class 3: busy, prepare buffer, data request within 20 ms, busy clears.
// - Sector count zero means 256 sectors; other values count directly.
// - Head number is the four-bit drive/head field, zero to fifteen.
// - Each command uses only its marked task-file registers, others ignored.
// - Block addressing is honoured only for commands that support it.
// - Decode read, write, multiple, DMA and verify transfer command codes.
// - Decode check power, idle, idle immediate, standby, standby immediate, sleep.
// - Code CDh is a multiple write without erase.
// - Code 38h is a sector write without erase.
// - Implement all supported commands, diagnostic, erase, identify, features, multiple.
// - Drive/head bit 6 chooses CHS when zero, block addressing when one.
// - While busy the host is locked out and only busy is valid.
// - Data request is set whenever host data transfer is needed.
`include "atc_cfg.svh"

module atc_core
   import atc_pkg::*;
#(
   parameter int unsigned DRQ2_CYCLES = 32'(`ATC_DRQ2_CYC),
   parameter int unsigned DRQ3_CYCLES = 32'(`ATC_DRQ3_CYC)
)
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [3:0]  tf_addr,
   input  wire logic        tf_wr,
   input  wire logic        tf_rd,
   input  wire logic [7:0]  tf_wdata,
   output logic      [7:0]  tf_rdata,
   input  wire logic        drive_id,
   input  wire logic        card_ready,
   input  wire logic        write_fault,
   input  wire logic        buf_ready,
   input  wire logic        cmd_done,
   input  wire logic        cmd_error,
   output logic             cmd_start,
   output logic      [7:0]  cmd_code,
   output logic             cmd_write,
   output logic             par_lba,
   output logic      [8:0]  par_count,
   output logic      [7:0]  par_feature,
   output logic      [7:0]  par_sector,
   output logic      [15:0] par_cyl,
   output logic      [3:0]  par_head,
   output logic             busy,
   output logic             drq
);

   localparam int BSY_LIMIT = `ATC_BSY_SET_CYC;

   // ======================================================================
   // Helpers
   // ======================================================================
   // A zero count stands for a full 256-sector request.
   function automatic logic [8:0] atc_sectors(input logic [7:0] sc);
      atc_sectors = (sc == 8'h00) ? 9'h100 : {1'b0, sc};
   endfunction

   // ======================================================================
   // Task-file storage
   // ======================================================================
   logic [7:0]  feature;
   logic [7:0]  scount;
   logic [7:0]  snum;
   logic [7:0]  cyl_lo;
   logic [7:0]  cyl_hi;
   logic [7:0]  dh;
   logic        srst;
   logic        busy_q;
   logic        err;
   logic [31:0] wd_cnt;
   atc_state_t  state;
   atc_class_t  cur_cls;
   atc_class_t  dec_cls;
   logic [5:0]  dec_use;
   logic        dec_write;
   logic        accept;
   logic        write_active;
   logic [31:0] wd_limit;
   logic [7:0]  status_val;
   logic [7:0]  echo_val;

   atc_decode u_decode (
      .code     (tf_wdata),
      .cls      (dec_cls),
      .use_mask (dec_use),
      .is_write (dec_write)
   );

   // Soft reset holds the card busy, so the lockout covers it too.
   assign busy = busy_q | srst;

   // Parameter writes are refused while busy; the host is locked out.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         feature <= 8'h00;
         scount  <= 8'h00;
         snum    <= 8'h00;
         cyl_lo  <= 8'h00;
         cyl_hi  <= 8'h00;
         dh      <= `ATC_DH_RST;
      end else if (clk_en && tf_wr && !busy) begin
         case (tf_addr)
            `ATC_OFF_FEAT_ERR: feature <= tf_wdata;
            `ATC_OFF_SCOUNT:   scount  <= tf_wdata;
            `ATC_OFF_SNUM:     snum    <= tf_wdata;
            `ATC_OFF_CYL_LO:   cyl_lo  <= tf_wdata;
            `ATC_OFF_CYL_HI:   cyl_hi  <= tf_wdata;
            `ATC_OFF_DH:       dh      <= tf_wdata;
            default: ;
         endcase
      end
   end

   // The control register stays writable while busy so a hung card can be reset.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         srst <= 1'b0;
      end else if (clk_en && tf_wr && tf_addr == `ATC_OFF_ALT_CTRL) begin
         srst <= tf_wdata[`ATC_CTRL_SRST_BIT];
      end
   end

   // ======================================================================
   // Command acceptance
   // ======================================================================
   // The code is taken only once the parameters sit in the file and busy is low.
   assign accept = clk_en && tf_wr && tf_addr == `ATC_OFF_STAT_CMD
                   && !busy && !drq;

   assign wd_limit = (cur_cls == ATC_CLS_3) ? DRQ3_CYCLES : DRQ2_CYCLES;

   // Busy is raised on the edge that takes the code, well inside the limit.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ATC_IDLE;
         busy_q    <= 1'b0;
         drq       <= 1'b0;
         err       <= 1'b0;
         cur_cls   <= ATC_CLS_NONE;
         cmd_write <= 1'b0;
         cmd_start <= 1'b0;
         cmd_code  <= 8'h00;
         wd_cnt    <= 32'h0;
      end else if (clk_en) begin
         cmd_start <= 1'b0;
         if (srst) begin
            state  <= ATC_IDLE;
            busy_q <= 1'b0;
            drq    <= 1'b0;
            err    <= 1'b0;
         end else begin
            case (state)
               ATC_IDLE: begin
                  if (accept) begin
                     busy_q    <= 1'b1;
                     err       <= 1'b0;
                     cur_cls   <= dec_cls;
                     cmd_write <= dec_write;
                     cmd_code  <= tf_wdata;
                     wd_cnt    <= 32'h0;
                     cmd_start <= (dec_cls != ATC_CLS_NONE);
                     case (dec_cls)
                        ATC_CLS_NONE: state <= ATC_FAIL;
                        ATC_CLS_1:    state <= ATC_EXEC;
                        default:      state <= ATC_PREP;
                     endcase
                  end
               end
               ATC_EXEC: begin
                  if (buf_ready) begin
                     drq   <= 1'b1;
                     state <= ATC_HANDOFF;
                  end else if (cmd_done) begin
                     busy_q <= 1'b0;
                     err    <= cmd_error;
                     state  <= ATC_IDLE;
                  end
               end
               ATC_PREP: begin
                  // A buffer that never comes ready ends the command in error.
                  if (buf_ready) begin
                     drq   <= 1'b1;
                     state <= ATC_HANDOFF;
                  end else if (wd_cnt >= wd_limit - 32'd1) begin
                     busy_q <= 1'b0;
                     err    <= 1'b1;
                     state  <= ATC_IDLE;
                  end else begin
                     wd_cnt <= wd_cnt + 32'd1;
                  end
               end
               ATC_HANDOFF: begin
                  busy_q <= 1'b0;
                  state  <= ATC_XFER;
               end
               ATC_XFER: begin
                  if (cmd_done) begin
                     drq   <= 1'b0;
                     err   <= cmd_error;
                     state <= ATC_IDLE;
                  end
               end
               ATC_FAIL: begin
                  busy_q <= 1'b0;
                  err    <= 1'b1;
                  state  <= ATC_IDLE;
               end
               default: state <= ATC_IDLE;
            endcase
         end
      end
   end

   // Parameters are latched through each command's usage mask; unused ones read zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         par_feature <= 8'h00;
         par_count   <= 9'h000;
         par_sector  <= 8'h00;
         par_cyl     <= 16'h0000;
         par_head    <= 4'h0;
         par_lba     <= 1'b0;
      end else if (accept) begin
         par_feature <= dec_use[`ATC_USE_FR] ? feature : 8'h00;
         par_count   <= dec_use[`ATC_USE_SC] ? atc_sectors(scount) : 9'h000;
         par_sector  <= dec_use[`ATC_USE_SN] ? snum : 8'h00;
         par_cyl     <= dec_use[`ATC_USE_CY] ? {cyl_hi, cyl_lo} : 16'h0000;
         par_head    <= dec_use[`ATC_USE_DH] ? dh[3:0] : 4'h0;
         par_lba     <= dec_use[`ATC_USE_LBA]
                        & dh[`ATC_DH_LBA_BIT];
      end
   end

   // ======================================================================
   // Read side
   // ======================================================================
   assign write_active = cmd_write && state != ATC_IDLE;

   // While busy nothing but busy is valid, so the rest reads as zero.
   always_comb begin
      if (busy) begin
         status_val = `ATC_BSY_ONLY;
      end else begin
         status_val = 8'h00;
         status_val[`ATC_ST_RDY] = card_ready;
         status_val[`ATC_ST_DWF] = write_fault;
         status_val[`ATC_ST_DSC] = card_ready;
         status_val[`ATC_ST_DRQ] = drq;
         status_val[`ATC_ST_ERR] = err;
      end
   end

   // Bit 7 is left low; the card does not own it and a floppy controller may.
   always_comb begin
      echo_val = 8'h00;
      echo_val[`ATC_ECHO_WR_GATE] = !write_active;
      echo_val[5:2] = ~dh[3:0];
      echo_val[`ATC_ECHO_DS1] = !(dh[`ATC_DH_DRV_BIT] && drive_id);
      echo_val[`ATC_ECHO_DS0] = !(!dh[`ATC_DH_DRV_BIT] && !drive_id);
   end

   // Reads answer one edge after the strobe.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tf_rdata <= 8'h00;
      end else if (clk_en && tf_rd) begin
         case (tf_addr)
            `ATC_OFF_FEAT_ERR: tf_rdata <= {5'h00, err, 2'b00};
            `ATC_OFF_SCOUNT:   tf_rdata <= scount;
            `ATC_OFF_SNUM:     tf_rdata <= snum;
            `ATC_OFF_CYL_LO:   tf_rdata <= cyl_lo;
            `ATC_OFF_CYL_HI:   tf_rdata <= cyl_hi;
            `ATC_OFF_DH:       tf_rdata <= dh;
            `ATC_OFF_STAT_CMD,
            `ATC_OFF_ALT_CTRL: tf_rdata <= status_val;
            `ATC_OFF_DRV_ECHO: tf_rdata <= echo_val;
            default:           tf_rdata <= 8'h00;
         endcase
      end
   end

   // ======================================================================
   // Checks
   // ======================================================================
   busy_on_accept_a: assert property (@(posedge clock) disable iff (!rst_n)
      accept |=> busy && $past(busy) == 1'b0 && BSY_LIMIT >= 1)
      else $error("busy not raised after command write");
   drq_then_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
      (state == ATC_PREP && buf_ready && clk_en && !srst) |=> drq && busy
      ##1 (!clk_en || !busy))
      else $error("busy did not clear after data request");
   prep_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
      state == ATC_PREP |-> wd_cnt < wd_limit)
      else $error("buffer preparation overran its limit");
   busy_masks_status_a: assert property (@(posedge clock) disable iff (!rst_n)
      busy |-> status_val == `ATC_BSY_ONLY)
      else $error("status bits visible while busy");
   drq_status_a: assert property (@(posedge clock) disable iff (!rst_n)
      !busy |-> status_val[`ATC_ST_DRQ] == drq && (drq || state != ATC_XFER))
      else $error("data request not reported");
   write_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
      echo_val[`ATC_ECHO_WR_GATE] == !(cmd_write && state != ATC_IDLE))
      else $error("write gate bit wrong");
   head_echo_a: assert property (@(posedge clock) disable iff (!rst_n)
      (echo_val[5:2] ^ dh[3:0]) == 4'hf)
      else $error("head echo not inverted");
   drive_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
      echo_val[`ATC_ECHO_DS1] == !(dh[`ATC_DH_DRV_BIT] & drive_id)
      && echo_val[`ATC_ECHO_DS0] != echo_val[`ATC_ECHO_DS1] | (drive_id
      != dh[`ATC_DH_DRV_BIT]))
      else $error("drive select echo wrong");
   count_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
      (accept && dec_use[`ATC_USE_SC] && scount == 8'h00) |=> par_count == 9'h100)
      else $error("zero sector count not taken as 256");
   unsupported_a: assert property (@(posedge clock) disable iff (!rst_n)
      (accept && dec_cls == ATC_CLS_NONE) |=> busy && !cmd_start
      ##1 (!clk_en || (!busy && err)))
      else $error("unsupported command did not end in error");

endmodule

// [test/atc_backend_model.sv]
// ==========================================================================
// Back-end model answering the command sequencer
// ==========================================================================
module atc_backend_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       cmd_start,
   input  wire logic       drq,
   input  wire logic [7:0] lat,
   input  wire logic       hang,
   input  wire logic       err_en,
   output logic            buf_ready,
   output logic            cmd_done,
   output logic            cmd_error
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      buf_ready = 1'b0;
      cmd_done  = 1'b0;
      cmd_error = 1'b1;
   end

   // Buffer ready after a programmable delay, completion a while into the data phase.
   // A hung back end never answers, so for class 2 and 3 the sequencer must give up by its own count.
   // A zero latency skips the buffer, so a class 1 command completes with no data phase.
   always @(posedge clock) begin
      if (rst_n && cmd_start && !hang) begin
         if (lat != 8'h00) begin
            repeat (lat) @(posedge clock);
            buf_ready <= 1'b1;
            @(posedge clock);
            buf_ready <= 1'b0;
            while (!drq) @(posedge clock);
         end
         repeat (6) @(posedge clock);
         cmd_done  <= 1'b1;
         cmd_error <= err_en;
         @(posedge clock);
         cmd_done  <= 1'b0;
         cmd_error <= ~err_en; // Qualifier is stale outside the done pulse.
      end
   end
endmodule

// [test/tb_atc_core.sv]
// ==========================================================================
// Self-checking bench for the command acceptance core
// ==========================================================================
module tb_atc_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst_n, tf_wr, tf_rd, drive_id, buf_ready, cmd_done, cmd_error;
   logic        cmd_start, cmd_write, par_lba, busy, drq, hang, err_en;
   logic        clk_en, card_ready, write_fault;
   logic [3:0]  tf_addr, par_head;
   logic [7:0]  tf_wdata, tf_rdata, cmd_code, par_feature, par_sector, lat;
   logic [8:0]  par_count;
   logic [15:0] par_cyl;
   logic [11:0] r;
   int          failures, num_checks, cycles, i, k;
   // Each row: command code, then write type, sector count used, block addressing.
   logic [11:0] rows [0:38] = '{12'h203, 12'h213, 12'h307, 12'h317, 12'hc43, 12'hc57,
      12'hc83, 12'hca7, 12'h403, 12'h413, 12'hcd7, 12'h387, 12'h3c7, 12'he50, 12'h980,
      12'he32, 12'h972, 12'he10, 12'h950, 12'he20, 12'h960, 12'he00, 12'h940, 12'he60,
      12'h990, 12'h900, 12'hec0, 12'hef0, 12'hc62, 12'hc03, 12'h507, 12'h912, 12'he40,
      12'h100, 12'h030, 12'h701, 12'h873, 12'hf50, 12'he84};

   atc_core #(.DRQ2_CYCLES(20), .DRQ3_CYCLES(40)) u_dut (.clock(clock), .rst_n(rst_n),
      .clk_en(clk_en), .tf_addr(tf_addr), .tf_wr(tf_wr), .tf_rd(tf_rd), .tf_wdata(tf_wdata),
      .tf_rdata(tf_rdata), .drive_id(drive_id), .card_ready(card_ready),
      .write_fault(write_fault), .buf_ready(buf_ready), .cmd_done(cmd_done), .cmd_error(cmd_error),
      .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_write(cmd_write), .par_lba(par_lba),
      .par_count(par_count), .par_feature(par_feature), .par_sector(par_sector),
      .par_cyl(par_cyl), .par_head(par_head), .busy(busy), .drq(drq));
   atc_backend_model u_model (.clock(clock), .rst_n(rst_n), .cmd_start(cmd_start),
      .drq(drq), .lat(lat), .hang(hang), .err_en(err_en), .buf_ready(buf_ready),
      .cmd_done(cmd_done), .cmd_error(cmd_error));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hang anywhere ends the run well after the expected thousand or so cycles.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobes rise one edge after entry, so back-to-back calls never collide.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock); #2;
      tf_addr = a; tf_wdata = d; tf_wr = 1'b1;
      @(posedge clock); #2;
      tf_wr = 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clock); #2;
      tf_addr = a; tf_rd = 1'b1;
      @(posedge clock); #2;
      tf_rd = 1'b0;
   endtask

   task automatic issue(input logic [7:0] code, input logic [7:0] sc, input logic [7:0] dh);
      wr(4'h2, sc);
      wr(4'h6, dh);
      wr(4'h7, code);
   endtask

   task automatic wait_idle();
      for (k = 0; k < 200 && (busy !== 1'b0 || drq !== 1'b0); k++) begin
         @(posedge clock); #2;
      end
      chk({busy, drq}, 16'h0000);
   endtask

   // Main sequence: reset, the row table, then the awkward cases.
   initial begin
      rst_n = 1'b0; tf_wr = 1'b0; tf_rd = 1'b0; tf_addr = 4'h0; tf_wdata = 8'h00;
      drive_id = 1'b0; lat = 8'h02; hang = 1'b0; err_en = 1'b0;
      clk_en = 1'b1; card_ready = 1'b1; write_fault = 1'b0;
      repeat (4) @(posedge clock);
      #2 rst_n = 1'b1;
      rd(4'h6); chk(tf_rdata, 8'ha0);
      // The echo is read only to be checked; no later stimulus depends on it.
      rd(4'hf); chk(tf_rdata, 8'h7e);
      for (i = 0; i < 39; i++) begin
         r = rows[i];
         issue(r[11:4], 8'h00, 8'he5);
         chk(cmd_start, 1'b1);
         chk(busy, 1'b1);
         chk(cmd_write, r[2]);
         chk(cmd_code, r[11:4]);
         chk(par_count, r[1] ? 9'h100 : 9'h000);
         chk(par_lba, r[0]);
         chk(par_head, 4'h5);
         for (k = 0; k < 100 && drq !== 1'b1; k++) begin
            @(posedge clock); #2;
         end
         chk(drq, 1'b1);
         rd(4'hf); chk(tf_rdata[6], !r[2]);
         wait_idle();
         rd(4'h7); chk(tf_rdata, 8'h50);
         rd(4'hf); chk(tf_rdata, 8'h6a);
      end
      issue(8'h20, 8'h07, 8'ha5);
      chk(par_count, 9'h007);
      chk(par_lba, 1'b0);
      wait_idle();
      issue(8'h00, 8'h00, 8'he5);
      chk(cmd_start, 1'b0);
      chk(cmd_code, 8'h00);
      wait_idle();
      rd(4'h7); chk(tf_rdata, 8'h51);
      hang = 1'b1;
      issue(8'h30, 8'h00, 8'he5);
      repeat (15) @(posedge clock);
      #2;
      chk(busy, 1'b1);
      wait_idle();
      rd(4'h7); chk(tf_rdata, 8'h51);
      // Class 3 outlasts the class 2 limit; a soft reset then aborts it.
      issue(8'h3c, 8'h00, 8'he5);
      repeat (25) @(posedge clock);
      #2;
      chk(busy, 1'b1);
      wr(4'he, 8'h04);
      rd(4'h7); chk(tf_rdata, 8'h80);
      wr(4'he, 8'h00);
      rd(4'h7); chk(tf_rdata, 8'h50);
      hang = 1'b0; err_en = 1'b1;
      issue(8'h20, 8'h00, 8'he5);
      wait_idle();
      card_ready = 1'b0; write_fault = 1'b1;
      rd(4'h7); chk(tf_rdata, 8'h21);
      card_ready = 1'b1; write_fault = 1'b0; lat = 8'h00;
      issue(8'he0, 8'h00, 8'he5);
      wait_idle();
      rd(4'h7); chk(tf_rdata, 8'h51);
      err_en = 1'b0; lat = 8'h0a;
      issue(8'hc5, 8'h00, 8'he5);
      wr(4'h2, 8'h33);
      wait_idle();
      rd(4'h2); chk(tf_rdata, 8'h00);
      // Unused parameter registers must not leak into a command.
      wr(4'h1, 8'h5a); wr(4'h3, 8'h11); wr(4'h4, 8'h22); wr(4'h5, 8'h33);
      issue(8'hef, 8'h00, 8'he5);
      chk({par_feature, par_sector}, 16'h5a00);
      chk(par_cyl, 16'h0000);
      wait_idle();
      issue(8'h20, 8'h00, 8'he5);
      chk({par_feature, par_sector}, 16'h0011);
      chk(par_cyl, 16'h3322);
      wait_idle();
      drive_id = 1'b1;
      wr(4'h6, 8'hb3);
      rd(4'hf); chk(tf_rdata, 8'h71);
      drive_id = 1'b0;
      rd(4'hf); chk(tf_rdata, 8'h73);
      // With the enable low a write must leave the head register untouched.
      clk_en = 1'b0;
      wr(4'h6, 8'he5);
      clk_en = 1'b1;
      rd(4'h6); chk(tf_rdata, 8'hb3);
      tally_and_finish();
   end
endmodule
